/* verilog/gca_alert.sv */
// Purpose: configuration word, charge warning flags, battery state and alert pin
// Assumes: charge_percent and average current sampled on clock; reset sync high
// Notes:   decoded controls lag the stored word by one cycle,
//          and the alert pin lags its source by one more;
//          reserved bits are stored exactly as the host writes them
`timescale 1ns/1ps
module gca_alert #(
   parameter int unsigned PULSE_LEN = gca_pkg::PULSE_CYCLES
) (
   // clock and reset
   input  wire logic             clock,
   input  wire logic             reset,
   // configuration word write port
   input  wire logic             cfg_write,
   input  wire logic [15:0]      cfg_wdata,
   output logic      [15:0]      operation_configuration,
   output gca_pkg::gca_ctrl_s    ctrl,
   // thresholds and gauge measurements
   input  wire logic [7:0]       step_interval,
   input  wire logic [7:0]       low_set_threshold,
   input  wire logic [7:0]       final_set_threshold,
   input  wire logic [7:0]       final_clear_threshold,
   input  wire logic [7:0]       charge_percent,
   input  wire logic [15:0]      design_capacity,
   input  wire logic signed [16:0] avg_current,
   input  wire logic             charge_term,
   // battery presence
   input  wire logic             insert_detect_in,
   input  wire logic             insert_cmd,
   input  wire logic             remove_cmd,
   output logic                  battery_present,
   output logic                  load_remaining_from_full,
   // flags, state and alert pin
   output logic                  charge_low_flag,
   output logic                  charge_final_flag,
   output gca_pkg::gca_batt_e    batt_state,
   output logic                  alert_out
);
   // a zero-length pulse is meaningless and the counter is 24 bits wide
   if (PULSE_LEN < 1 || PULSE_LEN > 32'h00FF_FFFF) begin : g_len_check
      $error("PULSE_LEN out of range");
   end

   // pulse timer
   logic [23:0]        pulse_cnt;
   logic [23:0]        next_pulse_cnt;
   logic               pulsing;
   logic               next_pulsing;

   // previous samples for crossing and pin edge detection
   logic [7:0]         prev_percent;
   logic               prev_pin;

   // next values of the registered outputs
   logic               next_low_flag;
   logic               next_final_flag;
   logic               next_present;
   logic               next_load;
   logic [8:0]         ctrl_bits;

   // word position of each decoded control, in struct order
   localparam int unsigned CTRL_POS [9] = '{
      gca_pkg::BIT_SENSE_COMP,
      gca_pkg::BIT_INSERT_PIN,
      gca_pkg::BIT_PULLUP,
      gca_pkg::BIT_GND_SEL,
      gca_pkg::BIT_SLEEP,
      gca_pkg::BIT_RM_FROM_FULL,
      gca_pkg::BIT_LOW_SELECT,
      gca_pkg::BIT_POLARITY,
      gca_pkg::BIT_HOST_TEMP
   };

   for (genvar c = 0; c < 9; c++) begin : g_pos_check
      if (CTRL_POS[c] >= gca_pkg::CFG_W) begin : g_bad
         $error("control bit outside the configuration word");
      end
   end

   // one decode per control bit
   for (genvar b = 0; b < 9; b++) begin : g_ctrl
      assign ctrl_bits[8 - b] = operation_configuration[CTRL_POS[b]];
   end

   // reserved bits are kept as written: setting them right is the host's duty
   wire logic [15:0] next_cfg = cfg_wdata;
   // thresholds in mA: capacity*10/divisor
   wire logic [19:0] cap_x10  = 20'(design_capacity) * 20'd10;
   wire logic [16:0] chg_thr  = 17'(cap_x10 / 20'(gca_pkg::CHG_DIV_TENTHS));
   wire logic [16:0] dsg_thr  = 17'(cap_x10 / 20'(gca_pkg::DSG_DIV_TENTHS));
   wire logic [16:0] quit_thr = 17'(cap_x10 / 20'(gca_pkg::QUIT_DIV_TENTHS));

   // hysteresis between quit and charge/discharge levels keeps state stable
   wire logic signed [17:0] cur = 18'(avg_current);
   wire logic is_chg   = cur >  $signed({1'b0, chg_thr});
   wire logic is_dsg   = cur < -$signed({1'b0, dsg_thr});
   wire logic is_quiet = (cur < $signed({1'b0, quit_thr})) && (cur > -$signed({1'b0, quit_thr}));
   gca_pkg::gca_batt_e next_state;
   always_comb begin
      next_state = batt_state;
      if (is_chg)
         next_state = gca_pkg::GCA_CHARGE;
      else if (is_dsg)
         next_state = gca_pkg::GCA_DISCHARGE;
      else if (is_quiet)
         next_state = gca_pkg::GCA_RELAX;
   end

   // crossing detection: a point is 0, 100 or 100 - n*interval
   function automatic logic on_grid(input logic [7:0] p, input logic [7:0] d);
      logic [7:0] diff;
      diff = 8'(gca_pkg::FULL_PERCENT - p);
      on_grid = (p == 8'h00) || (p <= gca_pkg::FULL_PERCENT && (diff % d) == 8'h00);
   endfunction

   // charge: any point q with prev < q <= now; discharge: now < q <= prev
   logic cross_up;
   logic cross_dn;
   always_comb begin
      cross_up = 1'b0;
      cross_dn = 1'b0;
      for (int q = 0; q <= 100; q++) begin
         if (step_interval != 8'h00 && on_grid(8'(q), step_interval)) begin
            if (prev_percent < 8'(q) && charge_percent >= 8'(q))
               cross_up = 1'b1;
            if (charge_percent < 8'(q) && prev_percent >= 8'(q))
               cross_dn = 1'b1;
         end
      end
   end

   // a crossing only counts while the state says which way charge moves
   wire logic step_on    = step_interval != 8'h00;
   wire logic in_charge  = batt_state == gca_pkg::GCA_CHARGE;
   wire logic in_dsg     = batt_state == gca_pkg::GCA_DISCHARGE;
   wire logic charge_ev  = in_charge && cross_up;
   wire logic dsg_ev     = in_dsg && cross_dn;
   wire logic state_ev   = step_on && next_state != batt_state;

   // detect pin edges; idle high is the pull-up level
   wire logic pin_mode   = ctrl.insert_detect_pin_enable;
   wire logic removal    = pin_mode && !prev_pin && insert_detect_in;
   wire logic insert_pin = pin_mode && prev_pin && !insert_detect_in;

   // events in one cycle merge into a single pulse
   wire logic event_any  = charge_ev || dsg_ev || state_ev || removal;

   // warning flags: a level equal to the set threshold holds the low flag
   wire logic low_set    = charge_percent < low_set_threshold;
   wire logic low_clr    = charge_percent > low_set_threshold;
   wire logic final_set  = charge_percent < final_set_threshold;
   // the final flag only clears once it has been set
   wire logic final_clr  = charge_final_flag && charge_percent > final_clear_threshold;
   assign next_low_flag   = low_set || (charge_low_flag && !low_clr);
   assign next_final_flag = final_set || (charge_final_flag && !final_clr);

   // a new event during a pulse restarts it rather than stacking
   wire logic        cnt_done = pulse_cnt == 24'h00_0000;
   wire logic [23:0] cnt_dec  = cnt_done ? pulse_cnt : pulse_cnt - 24'h00_0001;
   assign next_pulse_cnt = event_any ? 24'(PULSE_LEN - 1) : cnt_dec;
   assign next_pulsing   = event_any || (pulsing && !cnt_done);

   // pin level: function select first, then polarity
   wire logic active_lvl = ctrl.low_alert_select ? charge_low_flag : pulsing;
   wire logic pin_level  = ctrl.alert_polarity ? active_lvl : !active_lvl;

   // presence follows pin edges when enabled, host commands otherwise
   wire logic cmd_insert = !pin_mode && insert_cmd;
   wire logic cmd_remove = !pin_mode && remove_cmd;
   wire logic gone       = removal || cmd_remove;
   assign next_present   = insert_pin || cmd_insert || (battery_present && !gone);
   assign next_load      = charge_term && ctrl.remaining_from_full_on_term;

   // the stored word is what the host reads back
   always_ff @(posedge clock) begin
      if (reset) begin
         operation_configuration <= gca_pkg::CFG_RESET;
      end else if (cfg_write) begin
         operation_configuration <= next_cfg;
      end
   end

   // decoded controls lag the stored word by one cycle
   always_ff @(posedge clock) begin
      if (reset) begin
         ctrl <= '0;
      end else begin
         ctrl <= gca_pkg::gca_ctrl_s'(ctrl_bits);
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         charge_low_flag <= 1'b0;
      end else begin
         charge_low_flag <= next_low_flag;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         charge_final_flag <= 1'b0;
      end else begin
         charge_final_flag <= next_final_flag;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         pulse_cnt <= '0;
      end else begin
         pulse_cnt <= next_pulse_cnt;
      end
   end

   // pulsing drops one cycle after the count reaches zero: PULSE_LEN cycles high
   always_ff @(posedge clock) begin
      if (reset) begin
         pulsing <= 1'b0;
      end else begin
         pulsing <= next_pulsing;
      end
   end

   // previous percent marks where charge came from
   always_ff @(posedge clock) begin
      if (reset) begin
         prev_percent <= '0;
      end else begin
         prev_percent <= charge_percent;
      end
   end

   // resets high like the idle pin, so no false removal follows reset
   always_ff @(posedge clock) begin
      if (reset) begin
         prev_pin <= 1'b1;
      end else begin
         prev_pin <= insert_detect_in;
      end
   end

   // state holds in the band between the relax and move thresholds
   always_ff @(posedge clock) begin
      if (reset) begin
         batt_state <= gca_pkg::GCA_RELAX;
      end else begin
         batt_state <= next_state;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         battery_present <= 1'b0;
      end else begin
         battery_present <= next_present;
      end
   end

   // capacity update flag on termination: follows charge_term one cycle late, for as long as it stays high
   always_ff @(posedge clock) begin
      if (reset) begin
         load_remaining_from_full <= 1'b0;
      end else begin
         load_remaining_from_full <= next_load;
      end
   end

   // resets to the idle level of the default active-low polarity
   always_ff @(posedge clock) begin
      if (reset) begin
         alert_out <= 1'b1;
      end else begin
         alert_out <= pin_level;
      end
   end
endmodule // gca_alert

/* verilog/gca_pkg.sv */
// Purpose: constants and types for the gauge configuration and alert output block
// Assumes: 50 MHz clock, percentages as unsigned 0..100
// Notes:   configuration word bit positions and defaults
package gca_pkg;
   // configuration word layout
   localparam int unsigned CFG_W            = 16;
   localparam logic [15:0] CFG_RESET        = 16'h01F8;
   localparam logic [15:0] CFG_RESERVED_ZERO_MASK   = 16'h4600;
   localparam logic [15:0] CFG_RESERVED_ONE_MASK   = 16'h01C8;
   localparam int unsigned BIT_SENSE_COMP   = 15;
   localparam int unsigned BIT_INSERT_PIN   = 13;
   localparam int unsigned BIT_PULLUP       = 12;
   localparam int unsigned BIT_GND_SEL      = 11;
   localparam int unsigned BIT_SLEEP        = 5;
   localparam int unsigned BIT_RM_FROM_FULL = 4;
   localparam int unsigned BIT_LOW_SELECT   = 2;
   localparam int unsigned BIT_POLARITY     = 1;
   localparam int unsigned BIT_HOST_TEMP    = 0;
   // thresholds, percent
   localparam logic [7:0]  LOW_SET_RESET    = 8'h0A;
   localparam logic [7:0]  FINAL_SET_RESET  = 8'h02;
   localparam logic [7:0]  FINAL_CLR_RESET  = 8'h05;
   localparam logic [7:0]  FULL_PERCENT     = 8'h64;
   // state divisors in tenths: 13.3, 16.7, 25.0
   localparam int unsigned CHG_DIV_TENTHS   = 133;
   localparam int unsigned DSG_DIV_TENTHS   = 167;
   localparam int unsigned QUIT_DIV_TENTHS  = 250;
   // pulse timing
   localparam int unsigned CLK_HZ           = 50_000_000;
   localparam int unsigned PULSE_US         = 1000;
   localparam int unsigned PULSE_CYCLES     = CLK_HZ / 1_000_000 * PULSE_US;

   typedef enum logic [1:0] {GCA_RELAX, GCA_CHARGE, GCA_DISCHARGE} gca_batt_e;

   typedef struct packed {
      logic sense_comp_enable;
      logic insert_detect_pin_enable;
      logic detect_pullup_enable;
      logic adc_ground_select;
      logic sleep_allow;
      logic remaining_from_full_on_term;
      logic low_alert_select;
      logic alert_polarity;
      logic host_temp_write;
   } gca_ctrl_s;
endpackage

/* tb/gca_alert_properties.sv */
// Purpose: assertions on the alert block ports
// Assumes: one clock, reset sync high
// Notes:   pin activity judged against the polarity one cycle old
`timescale 1ns/1ps
module gca_alert_checker #(parameter int unsigned PULSE_LEN = 8) (
   // watched ports
   input wire logic               clock,
   input wire logic               reset,
   input wire logic [15:0]        operation_configuration,
   input wire gca_pkg::gca_ctrl_s ctrl,
   input wire logic [7:0]         step_interval,
   input wire logic [7:0]         low_set_threshold,
   input wire logic [7:0]         charge_percent,
   input wire logic               charge_term,
   input wire logic               insert_detect_in,
   input wire logic               load_remaining_from_full,
   input wire logic               charge_low_flag,
   input wire gca_pkg::gca_batt_e batt_state,
   input wire logic               alert_out
);
   logic pol_d;
   int   run;
   wire  act = (alert_out == pol_d);
   // the pin lags ctrl by a cycle, so a polarity change alone is no pulse
   always_ff @(posedge clock) begin
      pol_d <= reset ? 1'b0 : ctrl.alert_polarity;
      run   <= (reset || !act) ? 0 : run + 1;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   a_ctrl_follows: assert property (
      !$past(reset) |-> ctrl.low_alert_select == $past(operation_configuration[2]))
      else $error("select decode");
   a_low_pin: assert property (
      ctrl.low_alert_select && $past(ctrl.low_alert_select) |->
      alert_out == ($past(charge_low_flag) ~^ $past(ctrl.alert_polarity)))
      else $error("pin off low flag");
   a_low_set: assert property (
      charge_percent < low_set_threshold |-> ##[1:2] charge_low_flag) else $error("low set");
   a_low_clear: assert property (
      charge_percent > low_set_threshold |-> ##[1:2] !charge_low_flag) else $error("low clr");
   a_pulse_width: assert property (
      !ctrl.low_alert_select && $fell(act) |-> run >= PULSE_LEN) else $error("short pulse");
   a_state_pulse: assert property (
      !ctrl.low_alert_select && step_interval != 8'h00 && batt_state != $past(batt_state)
      |-> ##[0:2] act) else $error("no state pulse");
   a_removal_pulse: assert property (
      ctrl.insert_detect_pin_enable && !ctrl.low_alert_select && $rose(insert_detect_in)
      |-> ##[1:3] act) else $error("no removal pulse");
   a_full_load: assert property (
      load_remaining_from_full == ($past(charge_term) && $past(ctrl.remaining_from_full_on_term)))
      else $error("load pulse");
endmodule // gca_alert_checker
bind gca_alert gca_alert_checker #(.PULSE_LEN(PULSE_LEN)) props (.clock, .reset,
   .operation_configuration, .ctrl, .step_interval, .low_set_threshold, .charge_percent,
   .charge_term, .insert_detect_in, .load_remaining_from_full, .charge_low_flag,
   .batt_state, .alert_out);

/* tb/gca_host_model.sv */
// Purpose: host watching the alert pin, pack on the detect pin
// Assumes: pin sampled on the gauge clock
// Notes:   counts finished active runs, keeps the last length
`timescale 1ns/1ps
module gca_host_model (
   // pins
   input  wire logic clock,
   input  wire logic alert_out,
   output logic      insert_detect_in,
   // bench side
   input  wire logic active_high,
   input  wire logic battery_in,
   output int        pulses,
   output int        width
);
   int run = 0;
   // pull-up holds the pin high until a pack pulls it low
   assign insert_detect_in = !battery_in;
   initial pulses = 0;
   always @(posedge clock) begin
      run <= (alert_out == active_high) ? run + 1 : 0;
      if (alert_out != active_high && run != 0) begin
         pulses <= pulses + 1;
         width  <= run;
      end
   end
endmodule // gca_host_model

/* tb/test_gca_alert.sv */
// Purpose: self-checking bench for the alert block
// Assumes: pulse cut to 8 cycles, capacity 1330
// Notes:   host model counts pulses
`timescale 1ns/1ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin failures++; \
   $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module test_gca_alert;
   logic clock = 0, reset = 1, cfg_write = 0, charge_term = 0, battery_in = 0;
   logic insert_cmd = 0, remove_cmd = 0, active_high = 0, insert_detect_in;
   logic present, load_rm, low_flag, final_flag, alert_out;
   logic [15:0] cfg_wdata = 16'h0000, operation_configuration, w;
   logic [7:0] pct = 8'h32;
   logic signed [16:0] avg = 17'sh00000;
   gca_pkg::gca_ctrl_s ctrl;
   gca_pkg::gca_batt_e batt_state;
   int failures = 0, num_checks = 0, pulses, width, p0;
   int bits [9] = '{15, 13, 12, 11, 5, 4, 2, 1, 0};
   always #10 clock = ~clock;
   gca_alert #(.PULSE_LEN(8)) uut (.clock, .reset, .cfg_write, .cfg_wdata,
      .operation_configuration, .ctrl, .step_interval(8'h0A),
      .low_set_threshold(gca_pkg::LOW_SET_RESET), .final_set_threshold(gca_pkg::FINAL_SET_RESET),
      .final_clear_threshold(gca_pkg::FINAL_CLR_RESET), .charge_percent(pct),
      .design_capacity(16'h0532), .avg_current(avg), .charge_term, .insert_detect_in,
      .insert_cmd, .remove_cmd, .battery_present(present), .load_remaining_from_full(load_rm),
      .charge_low_flag(low_flag), .charge_final_flag(final_flag), .batt_state, .alert_out);
   gca_host_model host (.clock, .alert_out, .insert_detect_in, .active_high, .battery_in,
      .pulses, .width);
   task automatic tick(int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic wr(logic [15:0] v);
      tick(1);
      cfg_wdata <= v;
      cfg_write <= 1'b1;
      tick(1);
      cfg_write <= 1'b0;
      tick(2);
      @(negedge clock);
   endtask
   task automatic lvl(logic [7:0] p, logic lo, logic fi, logic al);
      tick(1);
      pct <= p;
      tick(4);
      @(negedge clock);
      `CHK("low", lo, low_flag)
      `CHK("final", fi, final_flag)
      `CHK("pin", al, alert_out)
   endtask
   task automatic wait_pulses(int n);
      for (int i = 0; i < 40 && pulses < n; i++) tick(1);
      @(negedge clock);
      `CHK("pulses", n, pulses)
      if (pulses < n) end_of_test;
   endtask
   task automatic ev(logic [7:0] p, logic signed [16:0] a, int n, gca_pkg::gca_batt_e s);
      tick(1);
      p0 = pulses + n;
      pct <= p;
      avg <= a;
      if (n == 0) tick(20);
      wait_pulses(p0);
      `CHK("state", s, batt_state)
   endtask
   task automatic end_of_test;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      tick(5);
      reset <= 1'b0;
      tick(1);
      charge_term <= 1'b1;
      tick(1);
      charge_term <= 1'b0;
      @(negedge clock);
      `CHK("load", 1'b1, load_rm)
      `CHK("cfg", gca_pkg::CFG_RESET, operation_configuration)
      `CHK("pin", 1'b1, alert_out)
      foreach (bits[i]) begin
         w = gca_pkg::CFG_RESERVED_ONE_MASK | (16'h0001 << bits[i]);
         wr(w);
         `CHK("word", w, operation_configuration)
         `CHK("ctrl", 9'h100 >> i, ctrl)
      end
      $display("config test done");
      wr(16'h01CE);
      lvl(8'h09, 1'b1, 1'b0, 1'b1);
      lvl(8'h0A, 1'b1, 1'b0, 1'b1);
      lvl(8'h0B, 1'b0, 1'b0, 1'b0);
      lvl(8'h01, 1'b1, 1'b1, 1'b1);
      lvl(8'h04, 1'b1, 1'b1, 1'b1);
      lvl(8'h06, 1'b1, 1'b0, 1'b1);
      wr(16'h01CC);
      lvl(8'h09, 1'b1, 1'b0, 1'b0);
      lvl(8'h32, 1'b0, 1'b0, 1'b1);
      $display("low test done");
      active_high <= 1'b1;
      wr(16'h01CA);
      tick(20);
      ev(8'h32, 17'sh00064, 0, gca_pkg::GCA_RELAX);
      ev(8'h32, 17'sh00065, 1, gca_pkg::GCA_CHARGE);
      `CHK("width", 8, width)
      ev(8'h3C, 17'sh00065, 1, gca_pkg::GCA_CHARGE);
      ev(8'h41, 17'sh00065, 0, gca_pkg::GCA_CHARGE);
      ev(8'h41, -17'sh00050, 1, gca_pkg::GCA_DISCHARGE);
      ev(8'h3B, -17'sh00050, 1, gca_pkg::GCA_DISCHARGE);
      ev(8'h32, -17'sh00050, 0, gca_pkg::GCA_DISCHARGE);
      ev(8'h31, -17'sh00050, 1, gca_pkg::GCA_DISCHARGE);
      ev(8'h31, 17'sh00034, 1, gca_pkg::GCA_RELAX);
      $display("step test done");
      wr(16'h21CA);
      tick(1);
      battery_in <= 1'b1;
      tick(4);
      @(negedge clock);
      `CHK("present", 1'b1, present)
      tick(1);
      p0 = pulses + 1;
      battery_in <= 1'b0;
      wait_pulses(p0);
      `CHK("present", 1'b0, present)
      wr(16'h01CA);
      tick(1);
      insert_cmd <= 1'b1;
      tick(1);
      insert_cmd <= 1'b0;
      tick(3);
      @(negedge clock);
      `CHK("present", 1'b1, present)
      tick(1);
      remove_cmd <= 1'b1;
      tick(1);
      remove_cmd <= 1'b0;
      tick(3);
      @(negedge clock);
      `CHK("present", 1'b0, present)
      $display("presence test done");
      end_of_test;
   end
endmodule // test_gca_alert
